// ---- core/irq_ctrl_consts.svh ----
// constants for the per-core interrupt controller
// assumes it is included by bare name from design files
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
`define IRQ_SLOTS         16
`define IRQ_VECTOR_BASE   24'h010000
`define IRQ_VECTOR_STEP   4
`define SLOT_RESET        0
`define SLOT_POWER_DOWN   1
`define SLOT_SINGLE_STEP  2
`define SLOT_STACK        3
`define SLOT_MAILBOX      4
`define SLOT_TIMER        5
`define SLOT_GPIO         6
`define SLOT_BUS_MASTER   7
`define SLOT_INTER_CORE   8
`define SLOT_FIFO0_TX     9
`define SLOT_FIFO0_RX     10
`define SLOT_FIFO1_TX     11
`define SLOT_FIFO1_RX     12
`define SLOT_CODEC_FRAME  15
`define NON_MASKABLE      16'h0007
`define ASSIGNED_SLOTS    16'h9fff
`define CTL_NEST_BIT      4
`define CTL_GLOBAL_BIT    5
`define CTL_PC_STACK_BIT  10
`define CTL_LOOP_STACK_BIT 11
`define CTL_RW_MASK       16'h0cb0
`define MASK_RESET        16'h0000
`define LATCH_RESET       16'h0000
`define CTL_RESET         16'h0000
`define PC_STACK_LOW      6'd3
`define PC_STACK_HIGH     6'd28
`endif

// ---- core/irq_ctrl_pkg.sv ----
// types for the per-core interrupt controller
// assumes nothing beyond the constants header
`default_nettype none
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    reg_mask    = 2'h0,
    reg_latch   = 2'h1,
    reg_control = 2'h2
  } reg_sel_t;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_issue = 2'b01,
    st_busy  = 2'b11
  } svc_state_t;
endpackage
`default_nettype wire

// ---- core/irq_priority_pick.sv ----
// fixed-priority picker: lowest set index wins
// assumes purely combinational use inside the controller
`default_nettype none
module irq_priority_pick #(
  parameter int SLOTS = 16
) (
  // request vector
  input  wire logic [SLOTS-1:0] i_req,
  // winner
  output logic                  o_any,
  output logic [3:0]            o_index
);
  always_comb begin
    o_any   = 1'b0;
    o_index = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any   = 1'b1;
        o_index = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/dsp_core_interrupt_controller.sv ----
// per-core prioritised interrupt controller feeding the program sequencer
// assumes sources give one-cycle pulses on i_clk; sequencer acks each vector
// How it works
// [R1] fourteen sources in sixteen prioritised slots
// [R2] slot 0 highest; offset is four times index
// [R3] vector is offset plus program memory base
// [R4] fixed source to slot map, shared indices
// [R5] latch anded with mask, highest wins
// [R6] reset, power-down unmaskable; disable blocks power-down
// [R7] nesting lets higher priority preempt service
// [R8] control register: global, nesting, stack enables
// [R9] control bits 4,5,10,11 as documented; bit 7 is also kept writable
// [R10] latch writable; after reset only the reset slot is serviced
// [R11] stack request when depth below 3 or above 28
// [R12] pending until vector taken or software clears
`include "irq_ctrl_consts.svh"
`default_nettype none
module dsp_core_interrupt_controller #(
  parameter int SLOTS = `IRQ_SLOTS
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // core register access
  input  wire logic        i_reg_wr,
  input  wire logic [1:0]  i_reg_sel,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  // global enable and disable instructions
  input  wire logic        i_global_enable_instruction,
  input  wire logic        i_global_disable_instruction,
  // sources, one-cycle pulses
  input  wire logic        i_src_reset,
  input  wire logic        i_src_power_down,
  input  wire logic        i_src_single_step,
  input  wire logic        i_src_mailbox,
  input  wire logic        i_src_timer,
  input  wire logic        i_src_gpio,
  input  wire logic        i_src_bus_master,
  input  wire logic        i_src_inter_core,
  input  wire logic        i_src_fifo0_tx,
  input  wire logic        i_src_fifo0_rx,
  input  wire logic        i_src_fifo1_tx,
  input  wire logic        i_src_fifo1_rx,
  input  wire logic        i_src_codec_frame,
  input  wire logic        i_src_emulation,
  // stack depths from the sequencer
  input  wire logic [5:0]  i_pc_stack_depth,
  input  wire logic        i_loop_stack_event,
  // sequencer handshake
  input  wire logic        i_vector_ack,
  input  wire logic        i_return,
  output logic             o_vector_valid,
  output logic      [23:0] o_vector_addr,
  output logic      [3:0]  o_vector_slot,
  output logic             o_emulation_req,
  output logic             o_in_service
);
  logic [15:0] interrupt_mask;
  logic [15:0] interrupt_latch;
  logic [15:0] interrupt_control;
  logic [15:0] active;
  logic [15:0] src_vec;
  logic [15:0] eligible;
  logic [15:0] preempt_mask;
  logic        pc_stack_level;
  logic        pick_any;
  logic [3:0]  pick_index;
  logic [3:0]  cur_prio;
  irq_ctrl_pkg::svc_state_t state;

  function automatic logic [23:0] vector_of(input logic [3:0] slot);
    vector_of = `IRQ_VECTOR_BASE + {18'h0, slot, 2'b00}; // [R2] [R3]
  endfunction

  function automatic logic [15:0] above(input logic [3:0] slot);
    above = (16'h0001 << slot) - 16'h0001;
  endfunction

  wire nest_en   = interrupt_control[`CTL_NEST_BIT];
  wire global_en = interrupt_control[`CTL_GLOBAL_BIT];

  assign pc_stack_level = interrupt_control[`CTL_PC_STACK_BIT] &&
                          ((i_pc_stack_depth < `PC_STACK_LOW) ||
                           (i_pc_stack_depth > `PC_STACK_HIGH)); // [R11]

  always_comb begin
    src_vec = 16'h0000;
    src_vec[`SLOT_RESET]       = i_src_reset; // [R4]
    src_vec[`SLOT_POWER_DOWN]  = i_src_power_down;
    src_vec[`SLOT_SINGLE_STEP] = i_src_single_step;
    src_vec[`SLOT_STACK]       = pc_stack_level ||
                                 (interrupt_control[`CTL_LOOP_STACK_BIT] && i_loop_stack_event);
    src_vec[`SLOT_MAILBOX]     = i_src_mailbox;
    src_vec[`SLOT_TIMER]       = i_src_timer;
    src_vec[`SLOT_GPIO]        = i_src_gpio;
    src_vec[`SLOT_BUS_MASTER]  = i_src_bus_master;
    src_vec[`SLOT_INTER_CORE]  = i_src_inter_core;
    src_vec[`SLOT_FIFO0_TX]    = i_src_fifo0_tx;
    src_vec[`SLOT_FIFO0_RX]    = i_src_fifo0_rx;
    src_vec[`SLOT_FIFO1_TX]    = i_src_fifo1_tx;
    src_vec[`SLOT_FIFO1_RX]    = i_src_fifo1_rx;
    src_vec[`SLOT_CODEC_FRAME] = i_src_codec_frame;
  end

  // reset slot always served; power-down and single-step need global enable only; rest needs mask too
  always_comb begin
    active = interrupt_latch & (interrupt_mask | `NON_MASKABLE); // [R5] [R6]
    if (!global_en) begin
      active = active & (16'h0001 << `SLOT_RESET); // [R6] [R10]
    end
    preempt_mask = 16'hffff;
    if (state == irq_ctrl_pkg::st_busy) begin
      preempt_mask = nest_en ? above(cur_prio) : 16'h0000; // [R7]
    end
    preempt_mask[`SLOT_RESET] = 1'b1;
    eligible = active & preempt_mask;
  end

  irq_priority_pick #(
    .SLOTS (SLOTS)
  ) u_pick (
    .i_req   (eligible),
    .o_any   (pick_any),
    .o_index (pick_index)
  ); // [R1] [R2]

  wire taken = o_vector_valid && i_vector_ack;

  // latch: set wins over any clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      interrupt_latch <= `LATCH_RESET;
    end else begin
      interrupt_latch <= (((i_reg_wr && i_reg_sel == irq_ctrl_pkg::reg_latch) ?
                           i_reg_wdata : interrupt_latch) &
                          ~(taken ? (16'h0001 << o_vector_slot) : 16'h0000))
                         | src_vec; // [R10] [R12]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      interrupt_mask <= `MASK_RESET;
    end else if (i_reg_wr && i_reg_sel == irq_ctrl_pkg::reg_mask) begin
      interrupt_mask <= i_reg_wdata & `ASSIGNED_SLOTS; // [R4]
    end
  end

  // global enable off at reset; instructions override a same-cycle write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      interrupt_control <= `CTL_RESET; // [R10]
    end else begin
      if (i_reg_wr && i_reg_sel == irq_ctrl_pkg::reg_control) begin
        interrupt_control <= i_reg_wdata & `CTL_RW_MASK; // [R8] [R9]
      end
      if (i_global_enable_instruction) begin
        interrupt_control[`CTL_GLOBAL_BIT] <= 1'b1;
      end
      if (i_global_disable_instruction) begin
        interrupt_control[`CTL_GLOBAL_BIT] <= 1'b0;
      end
    end
  end

  // service: one nesting level of priority is tracked; deeper returns restore idle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state          <= irq_ctrl_pkg::st_idle;
      o_vector_valid <= 1'b0;
      o_vector_slot  <= 4'h0;
      o_vector_addr  <= `IRQ_VECTOR_BASE;
      cur_prio       <= 4'hf;
    end else begin
      case (state)
        irq_ctrl_pkg::st_idle, irq_ctrl_pkg::st_busy: begin
          if (i_return && state == irq_ctrl_pkg::st_busy) begin
            state <= irq_ctrl_pkg::st_idle;
          end else if (pick_any) begin
            o_vector_valid <= 1'b1;
            o_vector_slot  <= pick_index;
            o_vector_addr  <= vector_of(pick_index); // [R3]
            state          <= irq_ctrl_pkg::st_issue;
          end
        end
        irq_ctrl_pkg::st_issue: begin
          if (i_vector_ack) begin
            o_vector_valid <= 1'b0;
            cur_prio       <= o_vector_slot;
            state          <= irq_ctrl_pkg::st_busy; // [R12]
          end
        end
        default: begin
          state <= irq_ctrl_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_emulation_req <= 1'b0;
      o_in_service    <= 1'b0;
    end else begin
      o_emulation_req <= i_src_emulation; // [R6]
      o_in_service    <= (state == irq_ctrl_pkg::st_busy);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_sel == irq_ctrl_pkg::reg_mask) begin
      o_reg_rdata <= interrupt_mask;
    end else if (i_reg_sel == irq_ctrl_pkg::reg_latch) begin
      o_reg_rdata <= interrupt_latch;
    end else if (i_reg_sel == irq_ctrl_pkg::reg_control) begin
      o_reg_rdata <= interrupt_control;
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- verification/irq_ctrl_sva.sv ----
// port assertions for the per-core interrupt controller
// assumes binding to the controller top, one clock domain
`default_nettype none
module irq_ctrl_sva (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [1:0]  i_reg_sel,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        i_src_emulation,
  input wire logic        o_emulation_req,
  input wire logic        i_vector_ack,
  input wire logic        i_return,
  input wire logic        o_vector_valid,
  input wire logic [23:0] o_vector_addr,
  input wire logic [3:0]  o_vector_slot,
  input wire logic        o_in_service
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_vector_addr: assert property (o_vector_valid |->
    o_vector_addr == 24'h010000 + {18'h0, o_vector_slot, 2'b00}) else $error("bad vector address");
  chk_vector_holds: assert property (o_vector_valid && !i_vector_ack |=>
    o_vector_valid && $stable(o_vector_slot)) else $error("vector changed before ack");
  chk_ack_clears: assert property (o_vector_valid && i_vector_ack |=>
    !o_vector_valid) else $error("vector stayed after ack");
  chk_service_lag: assert property (o_vector_valid && i_vector_ack |->
    ##2 o_in_service) else $error("service flag late");
  chk_return_idle: assert property (i_return && !o_vector_valid |->
    ##2 !o_in_service) else $error("service flag kept after return");
  chk_emul_pass: assert property (i_src_emulation |=>
    o_emulation_req) else $error("emulation request lost");
  chk_ctl_bits: assert property (i_reg_sel == 2'h2 |=>
    (o_reg_rdata & 16'hf34f) == 16'h0000) else $error("reserved control bit set");
  chk_mask_rsvd: assert property (i_reg_sel == 2'h0 |=>
    o_reg_rdata[14:13] == 2'b00) else $error("reserved mask bit set");
  cov_preempt: cover property (o_in_service && o_vector_valid);
  cov_slow_ack: cover property ((o_vector_valid && !i_vector_ack) [*3] ##1 i_vector_ack);
  cov_emul: cover property (o_emulation_req);
endmodule
bind dsp_core_interrupt_controller irq_ctrl_sva i_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_reg_sel(i_reg_sel), .o_reg_rdata(o_reg_rdata), .i_src_emulation(i_src_emulation),
  .o_emulation_req(o_emulation_req), .i_vector_ack(i_vector_ack), .i_return(i_return),
  .o_vector_valid(o_vector_valid), .o_vector_addr(o_vector_addr),
  .o_vector_slot(o_vector_slot), .o_in_service(o_in_service));
`default_nettype wire

// ---- verification/irq_sequencer_model.sv ----
// program sequencer model: takes each vector, returns later
// assumes the controller holds valid until the ack edge
`default_nettype none
module irq_sequencer_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  input  wire logic i_vector_valid,
  output logic      o_vector_ack,
  output logic      o_return
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_cnt = 0;
  int ret_cnt = 0;
  wire take = i_vector_valid && !o_vector_ack && (wait_cnt >= (i_slow ? 3 : 0));
  initial begin
    o_vector_ack = 1'b0;
    o_return = 1'b0;
  end
  // return is long enough that a preempting vector lands inside the routine
  // each output is assigned once per edge, so a pulse never collides with its own clear
  always @(negedge i_clk) begin
    o_vector_ack <= take;
    o_return <= (ret_cnt == 1);
    if (take) begin
      wait_cnt <= 0;
      ret_cnt <= 10;
    end else begin
      if (i_vector_valid && !o_vector_ack) wait_cnt <= wait_cnt + 1;
      if (ret_cnt > 0) ret_cnt <= ret_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/dsp_core_interrupt_controller_test.sv ----
// self-checking bench for the per-core interrupt controller
// assumes the sequencer model answers every vector
`default_nettype none
module dsp_core_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        wr_en = 1'b0;
  logic [1:0]  sel = 2'h3;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] src = 16'h0000;
  logic        gdis = 1'b0;
  logic        slow = 1'b0;
  logic [5:0]  depth = 6'h0a;
  logic [15:0] rdata;
  logic        ack, ret, valid, busy, emul;
  logic [23:0] addr;
  logic [3:0]  vslot;
  logic [5:0]  dv [4] = '{6'h03, 6'h1c, 6'h02, 6'h1d};
  int          slots [12] = '{0, 2, 4, 5, 6, 7, 8, 9, 10, 11, 12, 15};
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  always #5 i_clk = ~i_clk;
  dsp_core_interrupt_controller i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr_en),
    .i_reg_sel(sel), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_global_enable_instruction(src[14]), .i_global_disable_instruction(gdis),
    .i_src_reset(src[0]), .i_src_power_down(src[1]), .i_src_single_step(src[2]),
    .i_src_mailbox(src[4]), .i_src_timer(src[5]), .i_src_gpio(src[6]),
    .i_src_bus_master(src[7]), .i_src_inter_core(src[8]), .i_src_fifo0_tx(src[9]),
    .i_src_fifo0_rx(src[10]), .i_src_fifo1_tx(src[11]), .i_src_fifo1_rx(src[12]),
    .i_src_codec_frame(src[15]), .i_src_emulation(src[13]), .i_pc_stack_depth(depth),
    .i_loop_stack_event(src[3]), .i_vector_ack(ack), .i_return(ret), .o_vector_valid(valid),
    .o_vector_addr(addr), .o_vector_slot(vslot), .o_emulation_req(emul), .o_in_service(busy));
  irq_sequencer_model i_seq (.i_clk(i_clk), .i_slow(slow), .i_vector_valid(valid),
    .o_vector_ack(ack), .o_return(ret));
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge i_clk);
    sel = s;
    wdata = d;
    wr_en = 1'b1;
    @(negedge i_clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    @(negedge i_clk);
    sel = s;
    @(negedge i_clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic fire(input int b);
    @(negedge i_clk);
    src[b] = 1'b1;
    @(negedge i_clk);
    src[b] = 1'b0;
  endtask
  // a wrong vector is acked and gone within a few cycles, so watch every cycle
  task automatic idle_chk;
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(negedge i_clk);
      seen = seen | valid;
    end
    chk({23'h0, seen}, 24'h0);
  endtask
  // waits out the whole routine so the next vector starts from idle
  task automatic expect_vec(input logic [23:0] a);
    int k;
    for (k = 0; k < 40 && valid !== 1'b1; k++) @(negedge i_clk);
    chk(addr, a);
    chk({valid, 19'h0, vslot}, {1'b1, 19'h0, a[5:2]});
    for (k = 0; k < 40 && busy !== 1'b1; k++) @(negedge i_clk);
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge i_clk);
  endtask
  task automatic preempt_try(input logic nest);
    int k;
    for (k = 0; k < 40 && busy !== 1'b1; k++) @(negedge i_clk);
    fire(5);
    repeat (3) @(negedge i_clk);
    chk({23'h0, valid}, {23'h0, nest});
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(negedge i_clk);
    i_sys_rst = 1'b0;
    rd(2'h0, 16'h0000);
    rd(2'h1, 16'h0000);
    rd(2'h2, 16'h0000);
    wr(2'h2, 16'hffff);
    rd(2'h2, 16'h0cb0);
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'hffff);
    rd(2'h0, 16'h9fff);
    fire(1);
    fire(13);
    chk({23'h0, emul}, 24'h000001);
    idle_chk();
    rd(2'h1, 16'h0002);
    fire(14);
    expect_vec(24'h010004);
    rd(2'h1, 16'h0000);
    foreach (slots[j]) begin
      fire(slots[j]);
      expect_vec(24'h010000 + 24'(4 * slots[j]));
    end
    wr(2'h0, 16'h0000);
    fire(6);
    idle_chk();
    rd(2'h1, 16'h0040);
    wr(2'h0, 16'h0040);
    expect_vec(24'h010018);
    slow = 1'b1;
    wr(2'h0, 16'h9fff);
    wr(2'h1, 16'h8210);
    expect_vec(24'h010010);
    expect_vec(24'h010024);
    expect_vec(24'h01003c);
    wr(2'h1, 16'h8000);
    preempt_try(1'b0);
    expect_vec(24'h010014);
    wr(2'h2, 16'h0030);
    wr(2'h1, 16'h8000);
    preempt_try(1'b1);
    expect_vec(24'h010014);
    wr(2'h2, 16'h0420);
    wr(2'h0, 16'h0008);
    foreach (dv[j]) begin
      @(negedge i_clk);
      depth = dv[j];
      @(negedge i_clk);
      depth = 6'h0a;
      if (j < 2) idle_chk();
      else expect_vec(24'h01000c);
    end
    // each stack source raises a request only under its own enable
    fire(3);
    idle_chk();
    wr(2'h2, 16'h0820);
    @(negedge i_clk);
    depth = 6'h02;
    @(negedge i_clk);
    depth = 6'h0a;
    idle_chk();
    fire(3);
    expect_vec(24'h01000c);
    @(negedge i_clk);
    gdis = 1'b1;
    @(negedge i_clk);
    gdis = 1'b0;
    rd(2'h2, 16'h0800);
    // a second reset in mid-run must drop every enable again
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    rd(2'h2, 16'h0000);
    rd(2'h0, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
